// *** core/dtc_cnt_if.sv ***
// Interface between the control logic and one count unit
interface dtc_cnt_if;
   logic inc_low;
   logic inc_high;
   dtc_pkg::dtc_mode_t mode;
   logic wr_low;
   logic wr_high;
   logic [7:0] wdata;
   logic [7:0] low;
   logic [7:0] high;
   logic ovf_low;
   logic ovf_high;
   modport unit (
      input inc_low, inc_high, mode, wr_low, wr_high, wdata,
      output low, high, ovf_low, ovf_high
   );
   modport ctrl (
      output inc_low, inc_high, mode, wr_low, wr_high, wdata,
      input low, high, ovf_low, ovf_high
   );
endinterface

// *** core/dtc_count_unit.sv ***
// One timer's count registers with its four counting modes
module dtc_count_unit (
   input wire logic clk_i,
   input wire logic srst_i,
   dtc_cnt_if.unit cnt
);
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic ovf_low;
      logic ovf_high;
   } dtc_unit_state_t;

   dtc_unit_state_t s;
   dtc_unit_state_t next_s;

   always_comb begin
      logic [5:0] sum5;
      logic [8:0] sum8;
      logic [8:0] sumh;
      logic [16:0] sum16;
      sum5 = {1'b0, s.low[4:0]} + 6'h01;
      sum8 = {1'b0, s.low} + 9'h001;
      sumh = {1'b0, s.high} + 9'h001;
      sum16 = {1'b0, s.high, s.low} + 17'h0_0001;
      next_s = s;
      next_s.ovf_low = 1'b0;
      next_s.ovf_high = 1'b0;
      if (cnt.inc_low) begin
         case (cnt.mode)
            dtc_pkg::DTC_MODE_13BIT: begin
               // Five-bit prescaler in the low register, upper three bits untouched
               next_s.low[4:0] = sum5[4:0];
               if (sum5[5]) begin
                  next_s.high = sumh[7:0];
                  next_s.ovf_low = sumh[8];
               end
            end
            dtc_pkg::DTC_MODE_16BIT: begin
               next_s.low = sum16[7:0];
               next_s.high = sum16[15:8];
               next_s.ovf_low = sum16[16];
            end
            dtc_pkg::DTC_MODE_RELOAD8: begin
               next_s.low = sum8[8] ? s.high : sum8[7:0];
               next_s.ovf_low = sum8[8];
            end
            default: begin
               next_s.low = sum8[7:0];
               next_s.ovf_low = sum8[8];
            end
         endcase
      end
      if (cnt.inc_high) begin
         // Upper byte as its own 8-bit counter in split mode
         next_s.high = sumh[7:0];
         next_s.ovf_high = sumh[8];
      end
      // A software write takes precedence over a count in the same cycle
      if (cnt.wr_low) begin
         next_s.low = cnt.wdata;
      end
      if (cnt.wr_high) begin
         next_s.high = cnt.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s <= '{low: dtc_pkg::RST_COUNT, high: dtc_pkg::RST_COUNT, ovf_low: 1'b0,
                ovf_high: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign cnt.low = s.low;
   assign cnt.high = s.high;
   assign cnt.ovf_low = s.ovf_low;
   assign cnt.ovf_high = s.ovf_high;
endmodule

// *** core/dtc_pkg.sv ***
// Package: register map, field layout, reset values and phase constants of the dual timer
package dtc_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
   localparam logic [7:0] IDX_TIMER_A_COUNT_LOW = 8'h8A;
   localparam logic [7:0] IDX_TIMER_B_COUNT_LOW = 8'h8B;
   localparam logic [7:0] IDX_TIMER_A_COUNT_HIGH = 8'h8C;
   localparam logic [7:0] IDX_TIMER_B_COUNT_HIGH = 8'h8D;
   localparam logic [7:0] IDX_CLOCK_PRESCALE_CONTROL = 8'h8E;
   localparam logic [7:0] IDX_TOGGLE_CONTROL = 8'h90;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h91;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h92;
   localparam int unsigned ADDR_W = 10;

   // Reset values
   localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RST_TIMER_MODE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CLOCK_PRESCALE_CONTROL = 8'h00;
   localparam logic [1:0] RST_TWO_BITS = 2'h0;

   // Writable bits; the rest read as zero
   localparam logic [7:0] TIMER_CONTROL_WR_MASK = 8'hF0;
   localparam logic [7:0] CLOCK_PRESCALE_WR_MASK = 8'h18;

   // Per-timer field positions, index 0 is timer A, index 1 is timer B
   localparam int TIMER_CONTROL_FLAG_POS [2] = '{5, 7};
   localparam int TIMER_CONTROL_RUN_POS [2] = '{4, 6};
   localparam int TIMER_MODE_BASE [2] = '{0, 4};
   localparam int TIMER_MODE_FUNC_OFS = 2;
   localparam int TIMER_MODE_GATE_OFS = 3;
   localparam int CLOCK_PRESCALE_CONTROL_FAST_POS [2] = '{3, 4};

   // Machine cycle of twelve system clocks
   localparam logic [3:0] MC_LAST_PHASE = 4'hB;
   localparam logic [3:0] UPDATE_PHASE = 4'h2;
   localparam logic [3:0] SAMPLE_PHASE = 4'h3;
   // Fast ticks fall every fourth clock, on the phases whose low bits match update_phase
   localparam logic [1:0] FAST_TICK_PHASE = 2'h2;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD8 = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;
endpackage

// *** core/dtc_top.sv ***
// Dual 16-bit timer/counter with Avalon-MM register slave
// What this block does
// - two 16-bit counts, each high and low byte
// - overflow toggles the pin when enabled
// - timer ticks at clock over twelve or four
// - counter counts falling edges of own pin
// - pins sampled once per machine cycle, sample_phase
// - edge is high sample then low sample
// - counts update at update_phase, edge next cycle
// - function select is mode bit 2 and 6
// - two-bit mode field per timer
// - prescale bits 3 and 4, zero is divide twelve
// - control and mode registers configure both timers
// - edge counting at most once per 24 clocks
module dtc_top (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [dtc_pkg::ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   output logic irq_o,
   input wire logic timer_a_pin_i,
   output logic timer_a_pin_o,
   output logic timer_a_pin_oe_n_o,
   input wire logic timer_b_pin_i,
   output logic timer_b_pin_o,
   output logic timer_b_pin_oe_n_o,
   input wire logic timer_a_gate_i,
   input wire logic timer_b_gate_i
);
   typedef struct packed {
      logic [3:0] phase;
      logic [7:0] timer_control;
      logic [7:0] timer_mode;
      logic [7:0] clock_prescale_control;
      logic [1:0] toggle_control;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [1:0] samp;
      logic [1:0] pend;
      logic [1:0] pin;
      logic [1:0] pin_oe_n;
      logic wait_req;
      logic [7:0] rdata;
      logic irq;
   } dtc_state_t;

   dtc_state_t s;
   dtc_state_t next_s;

   logic acc;
   logic wr_en;
   logic rd_en;
   logic [1:0] pin_in;
   logic [1:0] gate_in;
   logic [1:0] inc_low;
   logic [1:0] inc_high;
   logic [1:0] wr_low;
   logic [1:0] wr_high;
   logic [1:0] ovf_low;
   logic [1:0] ovf_high;
   logic [1:0] ovf_event;
   logic [7:0] cnt_low [2];
   logic [7:0] cnt_high [2];
   logic [7:0] idx_low [2];
   logic [7:0] idx_high [2];

   // Word-aligned hit on a register index
   function automatic logic reg_hit(input logic [dtc_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
      reg_hit = (addr[1:0] == 2'h0) && (addr[dtc_pkg::ADDR_W-1:2] == idx);
   endfunction

   // Request is carried out in the cycle where waitrequest is low
   assign acc = (read_i | write_i) & ~s.wait_req;
   assign wr_en = acc & write_i & byteenable_i[0];
   assign rd_en = acc & read_i;
   assign pin_in = {timer_b_pin_i, timer_a_pin_i};
   assign gate_in = {timer_b_gate_i, timer_a_gate_i};
   assign idx_low = '{dtc_pkg::IDX_TIMER_A_COUNT_LOW, dtc_pkg::IDX_TIMER_B_COUNT_LOW};
   assign idx_high = '{dtc_pkg::IDX_TIMER_A_COUNT_HIGH, dtc_pkg::IDX_TIMER_B_COUNT_HIGH};
   assign ovf_event[0] = ovf_low[0];
   // Split mode lends timer A's upper byte to timer B's flag
   assign ovf_event[1] = ovf_low[1] | ovf_high[0];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         dtc_cnt_if cif();
         dtc_count_unit u_unit (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .cnt(cif.unit)
         );
         assign cif.inc_low = inc_low[gi];
         assign cif.inc_high = inc_high[gi];
         assign cif.mode = dtc_pkg::dtc_mode_t'(s.timer_mode[dtc_pkg::TIMER_MODE_BASE[gi] +: 2]);
         assign cif.wr_low = wr_low[gi];
         assign cif.wr_high = wr_high[gi];
         assign cif.wdata = writedata_i[7:0];
         assign cnt_low[gi] = cif.low;
         assign cnt_high[gi] = cif.high;
         assign ovf_low[gi] = cif.ovf_low;
         assign ovf_high[gi] = cif.ovf_high;
      end
   endgenerate

   // Count enables for both timers
   always_comb begin
      logic [1:0] tick;
      logic [1:0] enable;
      logic [1:0] src;
      logic [1:0] split;
      logic update_now;
      tick = 2'h0;
      enable = 2'h0;
      src = 2'h0;
      split = 2'h0;
      update_now = (s.phase == dtc_pkg::UPDATE_PHASE);
      for (int i = 0; i < 2; i++) begin
         // Fast rate ticks on phases 2, 6, 10; standard rate once per machine cycle
         if (s.clock_prescale_control[dtc_pkg::CLOCK_PRESCALE_CONTROL_FAST_POS[i]]) begin
            tick[i] = (s.phase[1:0] == dtc_pkg::FAST_TICK_PHASE);
         end else begin
            tick[i] = update_now;
         end
         enable[i] = s.timer_control[dtc_pkg::TIMER_CONTROL_RUN_POS[i]]
                     & (~s.timer_mode[dtc_pkg::TIMER_MODE_BASE[i] + dtc_pkg::TIMER_MODE_GATE_OFS]
                        | gate_in[i]);
         if (s.timer_mode[dtc_pkg::TIMER_MODE_BASE[i] + dtc_pkg::TIMER_MODE_FUNC_OFS]) begin
            src[i] = update_now & s.pend[i];
         end else begin
            src[i] = tick[i];
         end
         split[i] = (s.timer_mode[dtc_pkg::TIMER_MODE_BASE[i] +: 2] == dtc_pkg::DTC_MODE_SPLIT);
         wr_low[i] = wr_en & reg_hit(address_i, idx_low[i]);
         wr_high[i] = wr_en & reg_hit(address_i, idx_high[i]);
      end
      // Timer B halts in split mode; timer A's upper byte then runs on B's run bit
      inc_low[0] = enable[0] & src[0];
      inc_low[1] = enable[1] & src[1] & ~split[1];
      inc_high[0] = split[0] & s.timer_control[dtc_pkg::TIMER_CONTROL_RUN_POS[1]] & tick[0];
      inc_high[1] = 1'b0;
   end

   // Register file, sampling, flags and bus handshake
   always_comb begin
      logic [7:0] rval;
      rval = 8'h00;
      next_s = s;

      next_s.phase = (s.phase == dtc_pkg::MC_LAST_PHASE) ? 4'h0 : s.phase + 4'h1;

      // One sample per machine cycle; edge needs a high sample then a low one
      if (s.phase == dtc_pkg::SAMPLE_PHASE) begin
         next_s.samp = pin_in;
         for (int i = 0; i < 2; i++) begin
            if (s.samp[i] & ~pin_in[i]) begin
               next_s.pend[i] = 1'b1;
            end
         end
      end else if (s.phase == dtc_pkg::UPDATE_PHASE) begin
         // Edge caught last machine cycle is spent at this update phase
         next_s.pend = 2'h0;
      end

      // Software writes
      if (wr_en) begin
         if (reg_hit(address_i, dtc_pkg::IDX_TIMER_CONTROL)) begin
            next_s.timer_control = writedata_i[7:0] & dtc_pkg::TIMER_CONTROL_WR_MASK;
         end
         if (reg_hit(address_i, dtc_pkg::IDX_TIMER_MODE)) begin
            next_s.timer_mode = writedata_i[7:0];
         end
         if (reg_hit(address_i, dtc_pkg::IDX_CLOCK_PRESCALE_CONTROL)) begin
            next_s.clock_prescale_control = writedata_i[7:0]
                                            & dtc_pkg::CLOCK_PRESCALE_WR_MASK;
         end
         if (reg_hit(address_i, dtc_pkg::IDX_TOGGLE_CONTROL)) begin
            next_s.toggle_control = writedata_i[1:0];
         end
         if (reg_hit(address_i, dtc_pkg::IDX_IRQ_MASK)) begin
            next_s.irq_mask = writedata_i[1:0];
         end
      end

      // Reading status clears only the bits that were returned
      if (rd_en && reg_hit(address_i, dtc_pkg::IDX_IRQ_STATUS)) begin
         next_s.irq_status = s.irq_status & ~s.rdata[1:0];
      end

      // Hardware set wins over a software clear in the same cycle
      for (int i = 0; i < 2; i++) begin
         if (ovf_event[i]) begin
            next_s.timer_control[dtc_pkg::TIMER_CONTROL_FLAG_POS[i]] = 1'b1;
            next_s.irq_status[i] = 1'b1;
            if (s.toggle_control[i]) begin
               next_s.pin[i] = ~s.pin[i];
            end
         end
      end
      next_s.pin_oe_n = ~next_s.toggle_control;
      next_s.irq = |(next_s.irq_status & next_s.irq_mask);

      // Read mux; unmapped addresses read zero
      if (address_i[1:0] == 2'h0) begin
         case (address_i[dtc_pkg::ADDR_W-1:2])
            dtc_pkg::IDX_TIMER_CONTROL: rval = s.timer_control;
            dtc_pkg::IDX_TIMER_MODE: rval = s.timer_mode;
            dtc_pkg::IDX_TIMER_A_COUNT_LOW: rval = cnt_low[0];
            dtc_pkg::IDX_TIMER_B_COUNT_LOW: rval = cnt_low[1];
            dtc_pkg::IDX_TIMER_A_COUNT_HIGH: rval = cnt_high[0];
            dtc_pkg::IDX_TIMER_B_COUNT_HIGH: rval = cnt_high[1];
            dtc_pkg::IDX_CLOCK_PRESCALE_CONTROL: rval = s.clock_prescale_control;
            dtc_pkg::IDX_TOGGLE_CONTROL: rval = {6'h00, s.toggle_control};
            dtc_pkg::IDX_IRQ_STATUS: rval = {6'h00, s.irq_status};
            dtc_pkg::IDX_IRQ_MASK: rval = {6'h00, s.irq_mask};
            default: rval = 8'h00;
         endcase
      end

      // Waitrequest drops for one cycle, one cycle after a request appears
      if (acc) begin
         next_s.wait_req = 1'b1;
      end else if ((read_i | write_i) & s.wait_req) begin
         next_s.wait_req = 1'b0;
         next_s.rdata = read_i ? rval : 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s <= '{phase: 4'h0,
                timer_control: dtc_pkg::RST_TIMER_CONTROL,
                timer_mode: dtc_pkg::RST_TIMER_MODE,
                clock_prescale_control: dtc_pkg::RST_CLOCK_PRESCALE_CONTROL,
                toggle_control: dtc_pkg::RST_TWO_BITS,
                irq_status: dtc_pkg::RST_TWO_BITS,
                irq_mask: dtc_pkg::RST_TWO_BITS,
                samp: dtc_pkg::RST_TWO_BITS,
                pend: dtc_pkg::RST_TWO_BITS,
                pin: dtc_pkg::RST_TWO_BITS,
                pin_oe_n: 2'h3,
                wait_req: 1'b1,
                rdata: 8'h00,
                irq: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign readdata_o = {24'h00_0000, s.rdata};
   assign waitrequest_o = s.wait_req;
   assign irq_o = s.irq;
   assign timer_a_pin_o = s.pin[0];
   assign timer_b_pin_o = s.pin[1];
   assign timer_a_pin_oe_n_o = s.pin_oe_n[0];
   assign timer_b_pin_oe_n_o = s.pin_oe_n[1];
endmodule

// *** verification/dtc_pin_model.sv ***
// Pin side model: external count sources and toggle output observer
module dtc_pin_model (
   input wire logic clk_i,
   input wire logic a_out_i,
   input wire logic a_oe_n_i,
   input wire logic b_out_i,
   input wire logic b_oe_n_i,
   output logic a_line_o,
   output logic b_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic a_src = 1'b1;
   logic b_src = 1'b1;
   logic a_prev = 1'b0;
   int a_toggles = 0;
   // Line level: the block drives it while its enable is low
   assign a_line_o = a_oe_n_i ? a_src : a_out_i;
   assign b_line_o = b_oe_n_i ? b_src : b_out_i;
   always @(posedge clk_i) begin
      a_prev <= a_out_i;
      if (!a_oe_n_i && a_prev !== a_out_i) a_toggles <= a_toggles + 1;
   end
   // Each level lasts 25 clocks so every edge spans two samples
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         for (int lvl = 0; lvl < 2; lvl++) begin
            @(posedge clk_i);
            if (which == 0) a_src <= lvl[0];
            else b_src <= lvl[0];
            repeat (24) @(posedge clk_i);
         end
      end
   endtask
endmodule

// *** verification/dtc_top_assertions.sv ***
// Checker: bus handshake, toggle pins and interrupt of the dual timer
module dtc_top_assertions (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire logic irq_o,
   input wire logic timer_a_pin_o,
   input wire logic timer_a_pin_oe_n_o,
   input wire logic timer_b_pin_o,
   input wire logic timer_b_pin_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   property p_wait_one;
      !waitrequest_o |=> waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait state release too long");
   property p_wait_answer;
      (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no answer after one wait");
   property p_wait_cause;
      $fell(waitrequest_o) |-> $past(read_i || write_i);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_rdata_upper;
      !waitrequest_o |-> readdata_o[31:8] == 24'h00_0000;
   endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits not zero");
   property p_oe_a;
      $changed(timer_a_pin_oe_n_o) |-> $past(write_i && !waitrequest_o);
   endproperty
   a_oe_a: assert property (p_oe_a) else $error("pin A enable moved without write");
   property p_tog_a;
      $changed(timer_a_pin_o) |-> $past(!timer_a_pin_oe_n_o);
   endproperty
   a_tog_a: assert property (p_tog_a) else $error("pin A toggled while disabled");
   property p_tog_b;
      $changed(timer_b_pin_o) |-> $past(!timer_b_pin_oe_n_o);
   endproperty
   a_tog_b: assert property (p_tog_b) else $error("pin B toggled while disabled");
   property p_tog_rate_a;
      $changed(timer_a_pin_o) |=> $stable(timer_a_pin_o)[*3];
   endproperty
   a_tog_rate_a: assert property (p_tog_rate_a) else $error("pin A toggles too fast");
   property p_irq_fall;
      $fell(irq_o) |-> $past(!waitrequest_o && (read_i || write_i));
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without access");
   c_irq: cover property ($fell(irq_o));
   c_tog: cover property ($changed(timer_a_pin_o));
   c_read: cover property (!waitrequest_o && read_i);
endmodule

bind dtc_top dtc_top_assertions u_chk (.clk_i(clk_i), .srst_i(srst_i), .read_i(read_i),
   .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
   .timer_a_pin_o(timer_a_pin_o), .timer_a_pin_oe_n_o(timer_a_pin_oe_n_o),
   .timer_b_pin_o(timer_b_pin_o), .timer_b_pin_oe_n_o(timer_b_pin_oe_n_o));

// *** verification/tb.sv ***
// Self-checking bench for the dual timer/counter
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CTRL = dtc_pkg::IDX_TIMER_CONTROL;
   localparam logic [7:0] MODE = dtc_pkg::IDX_TIMER_MODE;
   localparam logic [7:0] LOW = dtc_pkg::IDX_TIMER_A_COUNT_LOW;
   localparam logic [7:0] CKC = dtc_pkg::IDX_CLOCK_PRESCALE_CONTROL;
   localparam logic [7:0] STA = dtc_pkg::IDX_IRQ_STATUS;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [9:0] address_i = 10'h000;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0000_0000;
   logic [3:0] byteenable_i = 4'h1;
   logic gate_a = 1'b0;
   logic [31:0] readdata_o;
   logic waitrequest_o, irq_o, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
   logic [7:0] v;
   int err_count = 0;
   int checked = 0;
   int seed = 32'h57ce;
   int cyc = 0;
   int mdl [4];
   int t0, na, nb, tg, base;
   dtc_top DUT (.clk_i(clk_i), .srst_i(srst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
      .timer_a_pin_i(a_in), .timer_a_pin_o(a_out), .timer_a_pin_oe_n_o(a_oe_n),
      .timer_b_pin_i(b_in), .timer_b_pin_o(b_out), .timer_b_pin_oe_n_o(b_oe_n),
      .timer_a_gate_i(gate_a), .timer_b_gate_i(1'b1));
   dtc_pin_model u_pins (.clk_i(clk_i), .a_out_i(a_out), .a_oe_n_i(a_oe_n), .b_out_i(b_out),
      .b_oe_n_i(b_oe_n), .a_line_o(a_in), .b_line_o(b_in));
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   task automatic tally_and_finish;
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic near(input string what, input int exp, input logic [15:0] got, input int tol);
      checked++;
      if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
         err_count++;
         $display("unexpected %s: expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk_i);
      address_i <= {idx, 2'b00};
      write_i <= wr;
      read_i <= !wr;
      writedata_i <= {24'h00_0000, wd};
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk_i);
      end while (waitrequest_o !== 1'b0);
      v = readdata_o[7:0];
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(what, {8'h00, exp}, {8'h00, v});
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      srst_i <= 1'b0;
      for (int k = 'h88; k <= 'h92; k++) rdc("reset value", 8'(k), 8'h00);
      bus(1, CTRL, 8'h0F);
      bus(1, CKC, 8'hE7);
      byteenable_i <= 4'h0;
      bus(1, MODE, 8'hFF);
      byteenable_i <= 4'h1;
      bus(1, 8'h87, 8'hFF);
      rdc("control reserved", CTRL, 8'h00);
      rdc("prescale reserved", CKC, 8'h00);
      rdc("mode unwritten", MODE, 8'h00);
      rdc("unmapped", 8'h87, 8'h00);
      for (int k = 0; k < 4; k++) begin
         mdl[k] = $random(seed) & 'hFF;
         bus(1, LOW + 8'(k), 8'(mdl[k]));
      end
      for (int k = 0; k < 4; k++) rdc("count byte", LOW + 8'(k), 8'(mdl[k]));
      // Counter function, 16-bit, edges from the pin model
      bus(1, MODE, 8'h55);
      bus(1, CTRL, 8'h50);
      na = 1 + ($random(seed) & 7);
      nb = 1 + ($random(seed) & 7);
      fork
         u_pins.pulse(0, na);
         u_pins.pulse(1, nb);
      join
      repeat (30) @(posedge clk_i);
      bus(1, CTRL, 8'h00);
      base = (mdl[2] * 256 + mdl[0] + na) & 'hFFFF;
      rdc("A edges low", LOW, 8'(base));
      rdc("A edges high", LOW + 8'h02, 8'(base >> 8));
      base = (mdl[3] * 256 + mdl[1] + nb) & 'hFFFF;
      rdc("B edges low", LOW + 8'h01, 8'(base));
      rdc("B edges high", LOW + 8'h03, 8'(base >> 8));
      for (int f = 0; f < 2; f++) begin
         bus(1, LOW + 8'h01, 8'h00);
         bus(1, LOW + 8'h03, 8'h00);
         bus(1, CKC, f ? 8'h10 : 8'h00);
         bus(1, MODE, 8'h10);
         bus(1, CTRL, 8'h40);
         t0 = cyc;
         repeat (240) @(posedge clk_i);
         bus(1, CTRL, 8'h00);
         // Run time spans from the end of the start write to the end of the stop write
         t0 = cyc - t0;
         rdc("B prescale", CKC, f ? 8'h10 : 8'h00);
         bus(0, LOW + 8'h01, 8'h00);
         near("B ticks", t0 / (f ? 4 : 12), {8'h00, v}, 1);
      end
      bus(1, CKC, 8'h08);
      bus(1, 8'h90, 8'h01);
      bus(1, 8'h92, 8'h01);
      for (int m = 0; m < 4; m++) begin
         bus(1, LOW, 8'hFF);
         bus(1, LOW + 8'h02, 8'hFF);
         bus(1, MODE, 8'(m));
         tg = u_pins.a_toggles;
         bus(1, CTRL, 8'h10);
         t0 = cyc;
         repeat (40) @(posedge clk_i);
         rdc("overflow flag", CTRL, 8'h30);
         bus(1, CTRL, 8'h00);
         check("pin enable", 16'h0000, {15'h0000, a_oe_n});
         check("pin B idle", 16'h0002, {14'h0000, b_oe_n, b_out});
         if (m == 2) near("toggles", (cyc - t0) / 4, 16'(u_pins.a_toggles - tg), 2);
         check("irq raised", 16'h0001, {15'h0000, irq_o});
         rdc("status", STA, 8'h01);
         @(posedge clk_i);
         check("irq cleared", 16'h0000, {15'h0000, irq_o});
      end
      // Start next to the wrap so an overflow falls inside the masked window
      bus(1, LOW, 8'hFF);
      bus(1, 8'h92, 8'h00);
      bus(1, CTRL, 8'h10);
      repeat (20) @(posedge clk_i);
      bus(1, CTRL, 8'h00);
      check("irq masked", 16'h0000, {15'h0000, irq_o});
      bus(1, 8'h92, 8'h01);
      repeat (2) @(posedge clk_i);
      check("irq unmasked", 16'h0001, {15'h0000, irq_o});
      rdc("status again", STA, 8'h01);
      bus(1, LOW, 8'h00);
      bus(1, MODE, 8'h09);
      bus(1, CTRL, 8'h10);
      repeat (60) @(posedge clk_i);
      rdc("gated count", LOW, 8'h00);
      gate_a <= 1'b1;
      t0 = cyc;
      repeat (60) @(posedge clk_i);
      bus(1, CTRL, 8'h00);
      bus(0, LOW, 8'h00);
      near("gate open", (cyc - t0) / 4, {8'h00, v}, 2);
      // Split mode: A's upper byte runs on B's run bit and sets B's flag, B holds
      bus(1, LOW + 8'h01, 8'h00);
      bus(1, LOW + 8'h02, 8'hFF);
      bus(1, MODE, 8'h33);
      bus(1, CTRL, 8'h40);
      repeat (20) @(posedge clk_i);
      rdc("split B flag", CTRL, 8'hC0);
      bus(1, CTRL, 8'h00);
      rdc("split B held", LOW + 8'h01, 8'h00);
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      tally_and_finish();
   end
endmodule
